/* File: rtl/qgc_pkg.sv */
// Shared constants for the quad gain-control link: register map, field
// positions, command layout and pin roles of the shared control pins.
package qgc_pkg;
  localparam int          NUM_CH      = 4;
  localparam int          ATT_W       = 5;
  localparam int          REG_W       = 8;
  localparam int          ADDR_W      = 3;
  localparam int          BYTE_BITS   = 8;
  localparam int          ACCESS_BITS = 16;
  localparam int          CNT_W       = 5;
  // Command byte
  localparam int          CMD_RD_BIT  = 7;
  localparam logic [2:0]  ADDR_CH_A   = 3'h0;
  localparam logic [2:0]  ADDR_FAST   = 3'h4;
  localparam logic [2:0]  PTR_RESET   = 3'h0;
  // Channel register fields
  localparam int          CH_RSV_BIT  = 7;
  localparam int          CH_PWR_BIT  = 6;
  localparam int          CH_EN_BIT   = 5;
  localparam logic [7:0]  CH_RESET    = 8'h00;
  localparam logic [7:0]  FAST_RESET  = 8'h00;
  // Gain step codes
  localparam logic [1:0]  STEP_DOWN   = 2'h1;
  localparam logic [1:0]  STEP_UP     = 2'h2;
  localparam logic [4:0]  ATT_MIN     = 5'h00;
  localparam logic [4:0]  ATT_MAX     = 5'h1f;
  // Shared pin roles (index into the 5-bit gain bus)
  localparam int          PIN_SDO     = 4;
  localparam int          PIN_SDI     = 3;
  localparam int          PIN_SEL     = 2;
  localparam int          PIN_SCLK    = 1;
  // Enable pin drive codes held by the controller
  localparam logic [1:0]  EN_OFF      = 2'h0;
  localparam logic [1:0]  EN_HIGH     = 2'h1;
  localparam logic [1:0]  EN_FLOAT    = 2'h2;
  // Controller register byte offsets and fields
  localparam logic [3:0]  WB_CMD      = 4'h0;
  localparam logic [3:0]  WB_STATUS   = 4'h4;
  localparam logic [3:0]  WB_PAR      = 4'h8;
  localparam int          CMD_ADDR_LO = 8;
  localparam int          CMD_RD_REQ  = 11;
  localparam int          PAR_MODE    = 5;
  localparam int          PAR_ENA_LO  = 6;
  localparam int          PAR_ENB_LO  = 8;
  localparam int          PAR_W       = 10;
  localparam logic [9:0]  PAR_RESET   = 10'h2a0;
  localparam int          STAT_RD_LO  = 8;
endpackage

/* File: rtl/qgc_if.sv */
// Pin-level carrier between the gain controller and the amplifier control
// logic. Resolves two-way and undriven pins: weak pull-ups on the gain
// pins, weak pull-down on the mode pin, float detection on enable pins.
`timescale 1ns/1ps
interface qgc_if;
  logic [4:0] pin_o;
  logic [4:0] pin_oe_n;
  logic       mode_o;
  logic       mode_oe_n;
  logic [1:0] en_o;
  logic [1:0] en_oe_n;
  logic       sdo_o;
  logic       sdo_oe_n;
  logic [4:0] pin;
  logic       mode;
  logic [1:0] en_lvl;
  logic [1:0] en_float;

  assign pin[3:0] = {~pin_oe_n[3:0] & pin_o[3:0]} | pin_oe_n[3:0];
  assign pin[4]   = !sdo_oe_n ? sdo_o : (!pin_oe_n[4] ? pin_o[4] : 1'b1);
  assign mode     = !mode_oe_n & mode_o;
  assign en_lvl   = ~en_oe_n & en_o;
  assign en_float = en_oe_n;

  modport host (output pin_o, pin_oe_n, mode_o, mode_oe_n, en_o, en_oe_n,
                input pin);
  modport dev  (output sdo_o, sdo_oe_n,
                input pin, mode, en_lvl, en_float);
endinterface

/* File: rtl/qgc_device.sv */
// Control logic of a four-channel digitally stepped gain block.
// Assumes every link pin is asynchronous to mclk; mclk must be well over
// four times the serial clock rate so both serial edges are seen.
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
module qgc_device
(
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  qgc_if.dev                         link,
  output logic [qgc_pkg::NUM_CH*qgc_pkg::ATT_W-1:0] atten,
  output logic [qgc_pkg::NUM_CH-1:0] ch_active,
  output logic [qgc_pkg::NUM_CH-1:0] ch_high_power,
  output logic                       serial_mode,
  output logic [qgc_pkg::ADDR_W-1:0] addr_ptr
);

  localparam int IN_W = 10;

  logic [IN_W-1:0]                 sync1_q;
  logic [IN_W-1:0]                 sync2_q;
  logic [4:0]                      pin_s;
  logic                            mode_s;
  logic [1:0]                      en_lvl_s;
  logic [1:0]                      en_float_s;
  logic                            sclk_prev_q;
  logic                            sel_act_q;
  logic                            sel_active;
  logic                            sclk_rise;
  logic                            sclk_fall;
  logic                            sel_start;
  logic                            commit;
  logic [qgc_pkg::CNT_W-1:0]       rise_cnt_q;
  logic [qgc_pkg::CNT_W-1:0]       fall_cnt_q;
  logic [qgc_pkg::ACCESS_BITS-1:0] shift_q;
  logic [qgc_pkg::REG_W-1:0]       rd_q;
  logic                            sdo_q;
  logic [qgc_pkg::REG_W-1:0]       ch_q [qgc_pkg::NUM_CH];
  logic [qgc_pkg::REG_W-1:0]       fast_q;
  logic [qgc_pkg::ADDR_W-1:0]      ptr_q;
  logic [qgc_pkg::ATT_W-1:0]       par_att_q [qgc_pkg::NUM_CH];
  logic [qgc_pkg::REG_W-1:0]       cmd;
  logic [qgc_pkg::REG_W-1:0]       wdata;
  logic [qgc_pkg::REG_W-1:0]       cmd_next;

  // Register read with reserved bit forced low and unmapped codes as zero
  function automatic logic [7:0] read_reg(input logic [2:0] a,
                                          input logic [7:0] c0,
                                          input logic [7:0] c1,
                                          input logic [7:0] c2,
                                          input logic [7:0] c3,
                                          input logic [7:0] f);
    logic [7:0] r;
    r = '0;
    case (a)
      3'h0:               r = c0;
      3'h1:               r = c1;
      3'h2:               r = c2;
      3'h3:               r = c3;
      qgc_pkg::ADDR_FAST: r = f;
      default:            r = '0;
    endcase
    r[qgc_pkg::CH_RSV_BIT] = (a == qgc_pkg::ADDR_FAST) ? f[qgc_pkg::CH_RSV_BIT] : 1'b0;
    return r;
  endfunction

  // One gain step; code 11 is treated as no change
  function automatic logic [4:0] step_att(input logic [4:0] att, input logic [1:0] code);
    logic [4:0] r;
    r = att;
    if (code == qgc_pkg::STEP_DOWN && att != qgc_pkg::ATT_MIN)
      r = att - 5'h01;
    else if (code == qgc_pkg::STEP_UP && att != qgc_pkg::ATT_MAX)
      r = att + 5'h01;
    return r;
  endfunction

  // Two-stage synchroniser on every pin the block reads
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= {link.en_float, link.en_lvl, link.mode, link.pin};
      sync2_q <= sync1_q;
    end
  end

  assign pin_s      = sync2_q[4:0];
  assign mode_s     = sync2_q[5];
  assign en_lvl_s   = sync2_q[7:6];
  assign en_float_s = sync2_q[9:8];

  // Shared pins take their serial roles only while the mode pin is high
  assign sel_active = mode_s & ~pin_s[qgc_pkg::PIN_SEL];
  assign sclk_rise  = sel_active & pin_s[qgc_pkg::PIN_SCLK] & ~sclk_prev_q;
  assign sclk_fall  = sel_active & ~pin_s[qgc_pkg::PIN_SCLK] & sclk_prev_q;
  assign sel_start  = sel_active & ~sel_act_q;
  // A frame counts only if exactly sixteen rising edges were seen
  assign commit     = sel_act_q & ~sel_active
                      & (rise_cnt_q == qgc_pkg::CNT_W'(qgc_pkg::ACCESS_BITS));
  assign cmd        = shift_q[15:8];
  assign wdata      = shift_q[7:0];
  assign cmd_next   = {shift_q[6:0], pin_s[qgc_pkg::PIN_SDI]};

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclk_prev_q <= 1'b0;
      sel_act_q   <= 1'b0;
    end
    else
    begin
      sclk_prev_q <= pin_s[qgc_pkg::PIN_SCLK];
      sel_act_q   <= sel_active;
    end
  end

  // Serial frame: shift on rising edges, drive readback on falling edges
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rise_cnt_q <= '0;
      fall_cnt_q <= '0;
      shift_q    <= '0;
      rd_q       <= '0;
      sdo_q      <= 1'b0;
    end
    else if (sel_start)
    begin
      rise_cnt_q <= '0;
      fall_cnt_q <= '0;
      sdo_q      <= 1'b0;
    end
    else if (sclk_rise)
    begin
      shift_q <= {shift_q[14:0], pin_s[qgc_pkg::PIN_SDI]};
      // Saturate just past sixteen so an overlong frame is caught
      if (rise_cnt_q <= qgc_pkg::CNT_W'(qgc_pkg::ACCESS_BITS))
        rise_cnt_q <= rise_cnt_q + 5'h01;
      if (rise_cnt_q == qgc_pkg::CNT_W'(qgc_pkg::BYTE_BITS - 1))
        rd_q <= read_reg(cmd_next[2:0], ch_q[0], ch_q[1], ch_q[2], ch_q[3], fast_q);
    end
    else if (sclk_fall)
    begin
      if (fall_cnt_q <= qgc_pkg::CNT_W'(qgc_pkg::ACCESS_BITS))
        fall_cnt_q <= fall_cnt_q + 5'h01;
      // Falls eight to fifteen carry the readback byte, MSB first
      if (fall_cnt_q >= qgc_pkg::CNT_W'(qgc_pkg::BYTE_BITS - 1) &&
          fall_cnt_q <  qgc_pkg::CNT_W'(qgc_pkg::ACCESS_BITS - 1))
      begin
        sdo_q <= rd_q[qgc_pkg::REG_W-1];
        rd_q  <= {rd_q[6:0], 1'b0};
      end
    end
  end

  // Output floats unless a serial access is under way
  assign link.sdo_o    = sdo_q;
  assign link.sdo_oe_n = ~sel_act_q;

  // Register file, touched only at the close of a complete frame
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < qgc_pkg::NUM_CH; i++)
        ch_q[i] <= qgc_pkg::CH_RESET;
      fast_q <= qgc_pkg::FAST_RESET;
      ptr_q  <= qgc_pkg::PTR_RESET;
    end
    else if (commit)
    begin
      ptr_q <= cmd[2:0];
      if (!cmd[qgc_pkg::CMD_RD_BIT])
      begin
        if (cmd[2:0] < qgc_pkg::ADDR_FAST)
          ch_q[cmd[1:0]] <= {1'b0, wdata[qgc_pkg::CH_PWR_BIT:0]};
        else if (cmd[2:0] == qgc_pkg::ADDR_FAST)
        begin
          fast_q <= wdata;
          for (int i = 0; i < qgc_pkg::NUM_CH; i++)
            ch_q[i][qgc_pkg::ATT_W-1:0] <= step_att(ch_q[i][qgc_pkg::ATT_W-1:0],
                                                    wdata[2*i +: 2]);
        end
      end
    end
  end

  // Parallel path: follow the gain pins only while the channel is on
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < qgc_pkg::NUM_CH; i++)
        par_att_q[i] <= qgc_pkg::ATT_MIN;
    end
    else if (!mode_s)
    begin
      for (int i = 0; i < qgc_pkg::NUM_CH; i++)
        if (en_float_s[i/2] | en_lvl_s[i/2])
          par_att_q[i] <= pin_s;
    end
  end

  // Gain circuit controls; pins pulled high read as all-ones attenuation
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      atten         <= '0;
      ch_active     <= '0;
      ch_high_power <= '0;
      serial_mode   <= 1'b0;
    end
    else
    begin
      serial_mode <= mode_s;
      for (int i = 0; i < qgc_pkg::NUM_CH; i++)
      begin
        if (mode_s)
        begin
          // Enable pins carry no meaning here
          atten[i*qgc_pkg::ATT_W +: qgc_pkg::ATT_W] <= ch_q[i][qgc_pkg::ATT_W-1:0];
          ch_active[i]     <= ch_q[i][qgc_pkg::CH_EN_BIT];
          ch_high_power[i] <= ch_q[i][qgc_pkg::CH_PWR_BIT];
        end
        else
        begin
          atten[i*qgc_pkg::ATT_W +: qgc_pkg::ATT_W] <= par_att_q[i];
          ch_active[i]     <= en_float_s[i/2] | en_lvl_s[i/2];
          ch_high_power[i] <= ~en_float_s[i/2] & en_lvl_s[i/2];
        end
      end
    end
  end

  assign addr_ptr = ptr_q;

endmodule

/* File: rtl/qgc_host.sv */
// Gain controller: a Wishbone classic slave holding its own command,
// status and parallel-drive registers, and the master end of the link.
// Assumes a single mclk; the serial clock is made from it by a divider.
`timescale 1ns/1ps
module qgc_host
#(
  parameter int HALF_PERIOD = 5
)
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  qgc_if.host              link,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o
);

  typedef enum logic [2:0] {S_IDLE, S_LEAD, S_SHIFT, S_TRAIL, S_GAP} state_e;

  state_e                           state_q;
  logic [7:0]                       div_q;
  logic                             tick;
  logic                             sclk_q;
  logic                             sel_n_q;
  logic [3:0]                       bits_q;
  logic [qgc_pkg::ACCESS_BITS-1:0]  tx_q;
  logic [qgc_pkg::REG_W-1:0]        rx_q;
  logic [1:0]                       sdo_sync_q;
  logic [qgc_pkg::PAR_W-1:0]        par_q;
  logic                             wb_hit;
  logic                             start;
  logic                             busy;
  logic                             serial;

  assign wb_hit = cyc_i & stb_i & ~ack_o;
  assign busy   = (state_q != S_IDLE);
  assign serial = par_q[qgc_pkg::PAR_MODE];
  assign start  = wb_hit & we_i & (adr_i == qgc_pkg::WB_CMD) & (&sel_i[1:0])
                  & serial & ~busy;
  assign tick   = (div_q == 8'(HALF_PERIOD - 1));

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      div_q <= '0;
    else
      div_q <= tick ? 8'h00 : div_q + 8'h01;
  end

  // Register slave; answers every address one cycle after the request
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_o <= 1'b0;
      dat_o <= '0;
      par_q <= qgc_pkg::PAR_RESET;
    end
    else
    begin
      ack_o <= wb_hit;
      if (wb_hit)
      begin
        dat_o <= '0;
        if (!we_i && adr_i == qgc_pkg::WB_STATUS)
          dat_o <= {16'h0000, rx_q, 7'h00, busy};
        else if (!we_i && adr_i == qgc_pkg::WB_PAR)
          dat_o <= {22'h00_0000, par_q};
        else if (we_i && adr_i == qgc_pkg::WB_PAR && (&sel_i[1:0]))
          par_q <= dat_i[qgc_pkg::PAR_W-1:0];
      end
    end
  end

  // Serial engine: select low, sixteen clocks, select high, idle gap
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= S_IDLE;
      sclk_q  <= 1'b0;
      sel_n_q <= 1'b1;
      bits_q  <= '0;
      tx_q    <= '0;
      rx_q    <= '0;
    end
    else
    begin
      case (state_q)
        S_IDLE:
          if (start)
          begin
            // Command first: read bit, four zeros, register code
            tx_q    <= {dat_i[qgc_pkg::CMD_RD_REQ], 4'h0,
                        dat_i[qgc_pkg::CMD_ADDR_LO +: qgc_pkg::ADDR_W],
                        dat_i[7:0]};
            sel_n_q <= 1'b0;
            bits_q  <= '0;
            state_q <= S_LEAD;
          end
        S_LEAD:
          if (tick)
            state_q <= S_SHIFT;
        S_SHIFT:
          if (tick)
          begin
            if (!sclk_q)
              sclk_q <= 1'b1;
            else
            begin
              rx_q   <= {rx_q[6:0], sdo_sync_q[1]};
              sclk_q <= 1'b0;
              tx_q   <= {tx_q[14:0], 1'b0};
              bits_q <= bits_q + 4'h1;
              if (bits_q == 4'(qgc_pkg::ACCESS_BITS - 1))
                state_q <= S_TRAIL;
            end
          end
        S_TRAIL:
          if (tick)
          begin
            sel_n_q <= 1'b1;
            state_q <= S_GAP;
          end
        S_GAP:
          if (tick)
            state_q <= S_IDLE;
        default:
          state_q <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      sdo_sync_q <= '0;
    else
      sdo_sync_q <= {sdo_sync_q[0], link.pin[qgc_pkg::PIN_SDO]};
  end

  // Gain bus drives all five bits together; serial mode frees the data pin
  always_comb
  begin
    link.pin_o    = par_q[qgc_pkg::ATT_W-1:0];
    link.pin_oe_n = 5'h00;
    if (serial)
    begin
      link.pin_o[qgc_pkg::PIN_SDI]    = tx_q[qgc_pkg::ACCESS_BITS-1];
      link.pin_o[qgc_pkg::PIN_SEL]    = sel_n_q;
      link.pin_o[qgc_pkg::PIN_SCLK]   = sclk_q;
      link.pin_o[qgc_pkg::PIN_SDO]    = 1'b0;
      link.pin_oe_n[qgc_pkg::PIN_SDO] = 1'b1;
    end
  end

  assign link.mode_o    = serial;
  assign link.mode_oe_n = 1'b0;
  assign link.en_o      = {par_q[qgc_pkg::PAR_ENB_LO] , par_q[qgc_pkg::PAR_ENA_LO]};
  assign link.en_oe_n   = {par_q[qgc_pkg::PAR_ENB_LO+1] , par_q[qgc_pkg::PAR_ENA_LO+1]};

endmodule

/* File: bench/qgc_link_asserts.sv */
// Link checker for the quad gain-control carrier: framing, serial clock
// discipline and the device's serial-out drive window.
// Assumes mclk runs well above four times the serial clock rate.
`timescale 1ns/1ps
module qgc_link_asserts
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [4:0] pin_oe_n,
  input  wire logic       mode_oe_n,
  input  wire logic       sdo_o,
  input  wire logic       sdo_oe_n,
  input  wire logic [4:0] pin,
  input  wire logic       mode
);
  logic [4:0] rise_cnt_q;

  // Counts serial clock rises inside one select-low window
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rise_cnt_q <= 5'h00;
    else if ($fell(pin[2]))
      rise_cnt_q <= 5'h00;
    else if (!pin[2] && $rose(pin[1]))
      rise_cnt_q <= rise_cnt_q + 5'h01;
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  AST_PULL_UP: assert property (((pin_oe_n & {sdo_oe_n, 4'hf}) & ~pin) == 5'h00)
    else $error("undriven gain pins not high");
  AST_MODE_PULL_DOWN: assert property (mode_oe_n |-> !mode)
    else $error("undriven mode pin not low");
  AST_PAR_NO_SDO: assert property (!mode [*4] |-> sdo_oe_n)
    else $error("serial out driven in parallel mode");
  AST_SDO_ON: assert property ($past(mode) && mode && $fell(pin[2]) |-> ##[1:5] !sdo_oe_n)
    else $error("serial out not driven after select");
  AST_SDO_OFF: assert property ($past(mode) && mode && $rose(pin[2]) |-> ##[1:5] sdo_oe_n)
    else $error("serial out not released after select");
  AST_SDO_IDLE: assert property ((mode && pin[2]) [*6] |-> sdo_oe_n)
    else $error("serial out driven while not selected");
  AST_SDO_HOLD: assert property (mode && !pin[2] && $rose(pin[1]) |-> ##1 $stable(sdo_o) [*4])
    else $error("serial out moved near a rising clock");
  AST_SDI_ON_LOW: assert property ($past(mode) && mode && !pin[2] && $changed(pin[3]) |-> !pin[1])
    else $error("serial in changed while clock high");
  AST_SCLK_IDLE: assert property ($past(mode) && mode && pin[2] |-> !pin[1])
    else $error("serial clock high between frames");
  AST_SIXTEEN: assert property ($past(mode) && mode && $rose(pin[2]) |-> rise_cnt_q == 5'h10)
    else $error("frame not sixteen clocks");

  cover property ($past(mode) && $rose(pin[2]) && rise_cnt_q == 5'h10);
  cover property (!sdo_oe_n && $fell(pin[1]));
  cover property (!mode && $changed(pin[3:0]));
endmodule

/* File: bench/quad_gain_control_interface_bench.sv */
// Bench for the quad gain-control link: host and device joined by one
// carrier, plus a second device whose link the bench drives itself.
// Assumes 125 MHz mclk and the host's default serial divider.
`timescale 1ns/1ps
module quad_gain_control_interface_bench;
  logic        mclk;
  logic        rst_n;
  logic        cyc, stb, we;
  logic [3:0]  adr, sel;
  logic [31:0] dat_w, dat_r;
  logic        ack;
  logic [19:0] atten, atten2;
  logic [3:0]  act, act2, hp, hp2;
  logic        smode, smode2;
  logic [2:0]  ptr, ptr2;
  logic [31:0] dev, dev2;
  logic [31:0] exp_q[$];
  logic [4:0]  m_att[4];
  logic [3:0]  m_act, m_hp;
  logic [7:0]  d, b;
  logic [4:0]  g;
  logic [1:0]  ab, cd, code;
  integer      seed, error_cnt, check_count, cyc_cnt;

  qgc_if qgc_if_i();
  qgc_if rule_if();
  assign dev  = {atten, act, hp, smode, ptr};
  assign dev2 = {atten2, act2, hp2, smode2, ptr2};

  qgc_host qgc_host_i (.mclk(mclk), .rst_n(rst_n), .link(qgc_if_i.host), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r),
    .ack_o(ack));
  qgc_device qgc_device_i (.mclk(mclk), .rst_n(rst_n), .link(qgc_if_i.dev), .atten(atten),
    .ch_active(act), .ch_high_power(hp), .serial_mode(smode), .addr_ptr(ptr));
  qgc_device rogue_device_i (.mclk(mclk), .rst_n(rst_n), .link(rule_if.dev), .atten(atten2),
    .ch_active(act2), .ch_high_power(hp2), .serial_mode(smode2), .addr_ptr(ptr2));
  qgc_link_asserts qgc_link_asserts_i (.mclk(mclk), .rst_n(rst_n),
    .pin_oe_n(qgc_if_i.pin_oe_n), .mode_oe_n(qgc_if_i.mode_oe_n), .sdo_o(qgc_if_i.sdo_o),
    .sdo_oe_n(qgc_if_i.sdo_oe_n), .pin(qgc_if_i.pin), .mode(qgc_if_i.mode));

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic end_sim();
    if (error_cnt == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk_rd(input logic [31:0] e, input logic [31:0] v);
    check_count = check_count + 1;
    if (v !== e)
    begin
      error_cnt = error_cnt + 1;
      $display("BAD %0t read %h expected %h", $time, v, e);
    end
  endtask

  task automatic chk_dev(input logic [31:0] e, input logic [31:0] v);
    check_count = check_count + 1;
    if (v !== e)
    begin
      error_cnt = error_cnt + 1;
      $display("BAD %0t outputs %h expected %h", $time, v, e);
    end
  endtask

  function automatic logic [31:0] dexp(input logic md, input logic [2:0] p);
    dexp = {m_att[3], m_att[2], m_att[1], m_att[0], m_act, m_hp, md, p};
  endfunction

  // Read results are taken at the edge where ack is sampled high
  always @(posedge mclk)
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
      chk_rd(exp_q.pop_front(), dat_r);

  always @(posedge mclk)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 40000)
    begin
      error_cnt = error_cnt + 1;
      end_sim();
    end
  end

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= v;
    do
    begin
      @(posedge mclk);
      n = n + 1;
    end
    while (ack !== 1'b1 && n < 50);
    if (n == 50)
      error_cnt = error_cnt + 1;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h0000_0000);
  endtask

  // Poll reads run with an empty queue, so the monitor leaves them alone
  task automatic ser(input logic r, input logic [2:0] c, input logic [7:0] v);
    int n;
    n = 0;
    wb(1'b1, qgc_pkg::WB_CMD, {20'h0_0000, r, c, v});
    do
    begin
      wb(1'b0, qgc_pkg::WB_STATUS, 32'h0000_0000);
      n = n + 1;
    end
    while (dat_r[0] !== 1'b0 && n < 100);
    if (dat_r[0] !== 1'b0)
      error_cnt = error_cnt + 1;
    repeat (4) @(posedge mclk);
  endtask

  // Bench-made frame with n clocks; the device must drop any n other than 16
  task automatic raw(input logic [15:0] w, input int n);
    rule_if.pin_o[2] <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      rule_if.pin_o[3] <= w[4'(15 - i)];
      repeat (5) @(posedge mclk);
      rule_if.pin_o[1] <= 1'b1;
      repeat (5) @(posedge mclk);
      rule_if.pin_o[1] <= 1'b0;
    end
    repeat (5) @(posedge mclk);
    rule_if.pin_o[2] <= 1'b1;
    repeat (10) @(posedge mclk);
  endtask

  initial
  begin
    seed = 97946;
    error_cnt = 0;
    check_count = 0;
    cyc_cnt = 0;
    rst_n = 1'b0;
    {cyc, stb, we} = 3'h0;
    adr = 4'h0;
    sel = 4'hf;
    dat_w = 32'h0000_0000;
    rule_if.mode_o = 1'b1;
    rule_if.mode_oe_n = 1'b0;
    rule_if.pin_o = 5'h04;
    rule_if.pin_oe_n = 5'h11;
    rule_if.en_o = 2'h0;
    rule_if.en_oe_n = 2'h3;
    for (int c = 0; c < 4; c++)
      m_att[c] = 5'h00;
    m_act = 4'h0;
    m_hp = 4'h0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    // The controller leaves reset in serial mode, so the device follows it
    chk_dev(dexp(qgc_pkg::PAR_RESET[qgc_pkg::PAR_MODE], qgc_pkg::PTR_RESET), dev);
    rd(qgc_pkg::WB_PAR, {22'h00_0000, qgc_pkg::PAR_RESET});
    rd(4'hc, 32'h0000_0000);
    for (int i = 0; i < 4; i++)
    begin
      g = 5'($random(seed));
      ab = 2'(i);
      cd = 2'(3 - i);
      wb(1'b1, qgc_pkg::WB_PAR, {22'h00_0000, cd, ab, 1'b0, g});
      for (int c = 0; c < 4; c++)
      begin
        code = (c < 2) ? ab : cd;
        m_act[c] = (code != qgc_pkg::EN_OFF);
        m_hp[c] = (code == qgc_pkg::EN_HIGH);
        if (code != qgc_pkg::EN_OFF)
          m_att[c] = g;
      end
      repeat (8) @(posedge mclk);
      chk_dev(dexp(1'b0, 3'h0), dev);
      rd(qgc_pkg::WB_PAR, {22'h00_0000, cd, ab, 1'b0, g});
    end
    // Enable pins driven low in serial mode must have no effect
    wb(1'b1, qgc_pkg::WB_PAR, 32'h0000_003f);
    repeat (8) @(posedge mclk);
    for (int c = 0; c < 4; c++)
    begin
      d = {1'b1, 1'($random(seed)), 1'b1, 5'($random(seed))};
      ser(1'b0, 3'(c), d);
      m_att[c] = d[4:0];
      m_act[c] = 1'b1;
      m_hp[c] = d[6];
    end
    chk_dev(dexp(1'b1, 3'h3), dev);
    for (int c = 0; c < 4; c++)
    begin
      ser(1'b1, 3'(c), 8'h00);
      rd(qgc_pkg::WB_STATUS, {16'h0000, 1'b0, m_hp[c], 1'b1, m_att[c], 8'h00});
    end
    for (int c = 0; c < 4; c++)
    begin
      m_att[c] = (c == 0) ? 5'h00 : ((c == 1) ? 5'h1f : 5'h0a);
      m_hp[c] = 1'b0;
      ser(1'b0, 3'(c), {3'h1, m_att[c]});
    end
    // Code 11 is reserved; the device leaves such a channel as it was
    for (int k = 0; k < 4; k++)
    begin
      b = (k == 0) ? 8'h69 : ((k == 1) ? 8'h00 : ((k == 2) ? 8'h06 : 8'hc3));
      ser(1'b0, qgc_pkg::ADDR_FAST, b);
      for (int c = 0; c < 4; c++)
      begin
        code = b[2 * c +: 2];
        if (code == qgc_pkg::STEP_DOWN && m_att[c] != qgc_pkg::ATT_MIN)
          m_att[c] = m_att[c] - 5'h01;
        if (code == qgc_pkg::STEP_UP && m_att[c] != qgc_pkg::ATT_MAX)
          m_att[c] = m_att[c] + 5'h01;
      end
      chk_dev(dexp(1'b1, 3'h4), dev);
      ser(1'b1, qgc_pkg::ADDR_FAST, 8'h00);
      rd(qgc_pkg::WB_STATUS, {16'h0000, b, 8'h00});
    end
    ser(1'b1, 3'h5, 8'h00);
    rd(qgc_pkg::WB_STATUS, 32'h0000_0000);
    @(posedge mclk);
    raw(16'h003f, 15);
    raw(16'h023f, 17);
    chk_dev(32'h0000_0008, dev2);
    raw(16'h0135, 16);
    chk_dev({10'h000, 5'h15, 5'h00, 4'h2, 4'h0, 1'b1, 3'h1}, dev2);
    end_sim();
  end
endmodule
